// ==== hdl/chsb_channel.sv ====
// Half-duplex character serial buffer channel: receiver, transmitter,
// command decode and flag tests.
// Assumes one clock, bit_period >= 2, width and speed held static.
// Summary of operation
// - Character width is five to eight bits
// - One line, receive or transmit per mode
// - Transmit transfer loads buffer, clears transmit flag
// - Receive transfer returns character, clears buffer, flag
// - Start bit starts bit clock, shifted in
// - Sample line once every bit period
// - Full character copies, sets flag, stops clock
// - Idle until next start, then repeat
// - Start needs half bit of space
// - New character overwrites unread one
// - Reading clears data register and flag
// - Command 3 selects receive mode
// - Command 1 clears receive flag, buffer
// - Commands 5, 6, test 9 only full
// - Command 4 selects transmit mode
// - Empty shifter, clear flag: load, set, send
// - Flag still set: keep sending marks
`timescale 1ns/10ps
`default_nettype none
module chsb_channel
(
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        rx_line_in,
    output var  logic                        tx_line_q,
    input  wire logic [chsb_pkg::SEL_W-1:0]  char_width_sel,
    input  wire logic [chsb_pkg::DIV_W-1:0]  bit_period,
    input  wire logic                        full_variant,
    input  wire logic                        cmd_valid,
    input  wire logic [chsb_pkg::CMD_W-1:0]  cmd_code,
    input  wire logic                        tx_write,
    input  wire logic [chsb_pkg::DATA_W-1:0] tx_data,
    input  wire logic                        rx_read,
    output var  logic [chsb_pkg::DATA_W-1:0] rx_char_q,
    output var  logic                        rx_flag_q,
    output var  logic                        tx_flag_q,
    input  wire logic                        test_valid,
    input  wire logic [chsb_pkg::CMD_W-1:0]  test_code,
    output var  logic                        test_result_q,
    output var  logic                        rx_mode_q,
    output var  logic                        tx_mode_q
);
    import chsb_pkg::*;

    function automatic logic [BITS_W-1:0] char_bits(
        input logic [SEL_W-1:0] sel);
        char_bits = MIN_CHAR_BITS + BITS_W'(sel);
    endfunction

    function automatic logic [DATA_W-1:0] char_mask(
        input logic [SEL_W-1:0] sel);
        char_mask = DATA_W'((9'h001 << char_bits(sel)) - 9'h001);
    endfunction

    logic                    line_s;
    logic [BITS_W-1:0]       nbits;
    logic [DIV_W-1:0]        half_period;
    logic                    ext_a;
    logic                    ext_b;
    chsb_mode_e              mode_q, mode_d;
    chsb_state_e             rx_st_q, rx_st_d;

    chsb_sync2 u_rx_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  (rx_line_in),
        .pin_s_q (line_s)
    );

    // Width and speed are sampled live; changing them mid-frame corrupts it
    assign nbits       = char_bits(char_width_sel);
    assign half_period = bit_period >> 1;
    assign ext_a = cmd_valid && full_variant
                   && cmd_code == extended_control_cmd_a;
    assign ext_b = cmd_valid && full_variant
                   && cmd_code == extended_control_cmd_b;

    // Mode and test results
    logic test_d;

    always_comb
    begin
        mode_d = mode_q;
        if (cmd_valid && cmd_code == set_receive_mode_cmd)
            mode_d = CHSB_MODE_RX;
        else if (cmd_valid && cmd_code == set_transmit_mode_cmd)
            mode_d = CHSB_MODE_TX;
        test_d = test_result_q;
        if (test_valid)
        begin
            case (test_code)
                rx_flag_test:       test_d = rx_flag_q;
                tx_flag_test:       test_d = tx_flag_q;
                extended_flag_test: test_d = full_variant
                                             && rx_st_q != CHSB_S_IDLE;
                default:            test_d = 1'h0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode_q        <= CHSB_MODE_OFF;
            test_result_q <= 1'h0;
            rx_mode_q     <= 1'h0;
            tx_mode_q     <= 1'h0;
        end
        else
        begin
            mode_q        <= mode_d;
            test_result_q <= test_d;
            rx_mode_q     <= mode_d == CHSB_MODE_RX;
            tx_mode_q     <= mode_d == CHSB_MODE_TX;
        end
    end

    // Receiver
    logic [DIV_W-1:0]      rx_cnt_q, rx_cnt_d;
    logic [BITS_W-1:0]     rx_bit_q, rx_bit_d;
    logic [SHIFT_W-1:0]    rx_sh_q, rx_sh_d;
    logic [DATA_W-1:0]     rx_data_q, rx_data_d;
    logic [DATA_W-1:0]     rx_char_d;
    logic                  rx_flag_d;
    logic                  rx_done;
    logic                  rx_clear;

    always_comb
    begin
        rx_st_d   = rx_st_q;
        rx_cnt_d  = rx_cnt_q + DIV_W'(1);
        rx_bit_d  = rx_bit_q;
        rx_sh_d   = rx_sh_q;
        rx_data_d = rx_data_q;
        rx_flag_d = rx_flag_q;
        rx_char_d = rx_char_q;
        rx_done   = 1'h0;
        case (rx_st_q)
            CHSB_S_IDLE:
            begin
                rx_cnt_d = DIV_W'(1);
                if (line_s == LINE_SPACE)
                    rx_st_d = CHSB_S_START;
            end
            CHSB_S_START:
            begin
                // Short space pulses fall back to idle
                if (line_s == LINE_MARK)
                    rx_st_d = CHSB_S_IDLE;
                else if (rx_cnt_q >= half_period)
                begin
                    rx_st_d  = CHSB_S_DATA;
                    rx_cnt_d = '0;
                    rx_bit_d = '0;
                    rx_sh_d  = {LINE_SPACE, rx_sh_q[SHIFT_W-1:1]};
                end
            end
            CHSB_S_DATA:
            begin
                // Full periods from mid-start land mid-bit
                if (rx_cnt_q == bit_period - DIV_W'(1))
                begin
                    rx_cnt_d = '0;
                    rx_sh_d  = {line_s, rx_sh_q[SHIFT_W-1:1]};
                    rx_bit_d = rx_bit_q + BITS_W'(1);
                    if (rx_bit_q == nbits - BITS_W'(1))
                        rx_st_d = CHSB_S_STOP;
                end
            end
            CHSB_S_STOP:
            begin
                // Stop level is not checked; no framing error exists
                if (rx_cnt_q == bit_period - DIV_W'(1))
                begin
                    rx_st_d = CHSB_S_IDLE;
                    rx_done = 1'h1;
                end
            end
            default:
                rx_st_d = CHSB_S_IDLE;
        endcase
        if (mode_q != CHSB_MODE_RX || ext_a)
            rx_st_d = CHSB_S_IDLE;
        rx_clear = rx_read
                   || (cmd_valid && cmd_code == clear_receive_cmd);
        if (rx_read)
            rx_char_d = rx_data_q & char_mask(char_width_sel);
        if (rx_clear)
        begin
            rx_data_d = '0;
            rx_flag_d = 1'h0;
        end
        // Arrival wins over a clear in the same cycle
        if (rx_done)
        begin
            rx_data_d = DATA_W'(rx_sh_q >> (BITS_W'(SHIFT_W) - nbits));
            rx_flag_d = 1'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_st_q   <= CHSB_S_IDLE;
            rx_cnt_q  <= '0;
            rx_bit_q  <= '0;
            rx_sh_q   <= '0;
            rx_data_q <= '0;
            rx_flag_q <= RX_FLAG_RST;
            rx_char_q <= '0;
        end
        else
        begin
            rx_st_q   <= rx_st_d;
            rx_cnt_q  <= rx_cnt_d;
            rx_bit_q  <= rx_bit_d;
            rx_sh_q   <= rx_sh_d;
            rx_data_q <= rx_data_d;
            rx_flag_q <= rx_flag_d;
            rx_char_q <= rx_char_d;
        end
    end

    // Transmitter
    chsb_state_e       tx_st_q, tx_st_d;
    logic [DIV_W-1:0]  tx_cnt_q, tx_cnt_d;
    logic [BITS_W-1:0] tx_bit_q, tx_bit_d;
    logic [DATA_W-1:0] tx_sh_q, tx_sh_d;
    logic [DATA_W-1:0] tx_buf_q, tx_buf_d;
    logic              tx_flag_d;
    logic              tx_line_d;
    logic              tx_end;

    always_comb
    begin
        tx_st_d   = tx_st_q;
        tx_bit_d  = tx_bit_q;
        tx_sh_d   = tx_sh_q;
        tx_buf_d  = tx_buf_q;
        tx_flag_d = tx_flag_q;
        tx_line_d = LINE_MARK;
        tx_end    = tx_cnt_q == bit_period - DIV_W'(1);
        tx_cnt_d  = tx_end ? '0 : tx_cnt_q + DIV_W'(1);
        if (tx_write)
        begin
            tx_buf_d  = tx_data & char_mask(char_width_sel);
            tx_flag_d = 1'h0;
        end
        case (tx_st_q)
            CHSB_S_IDLE:
            begin
                tx_cnt_d = '0;
                // A write defers the load one cycle so it is never lost
                if (mode_q == CHSB_MODE_TX && !tx_flag_q && !tx_write)
                begin
                    tx_st_d   = CHSB_S_START;
                    tx_sh_d   = tx_buf_q;
                    tx_flag_d = 1'h1;
                    tx_line_d = LINE_SPACE;
                end
            end
            CHSB_S_START:
            begin
                tx_line_d = LINE_SPACE;
                tx_bit_d  = '0;
                if (tx_end)
                begin
                    tx_st_d   = CHSB_S_DATA;
                    tx_line_d = tx_sh_q[0];
                end
            end
            CHSB_S_DATA:
            begin
                tx_line_d = tx_sh_q[0];
                if (tx_end)
                begin
                    tx_sh_d   = tx_sh_q >> 1;
                    tx_bit_d  = tx_bit_q + BITS_W'(1);
                    tx_line_d = tx_sh_q[1];
                    if (tx_bit_q == nbits - BITS_W'(1))
                    begin
                        tx_st_d   = CHSB_S_STOP;
                        tx_line_d = LINE_MARK;
                    end
                end
            end
            CHSB_S_STOP:
            begin
                // Idle after stop keeps marking while the flag stays set
                if (tx_end)
                    tx_st_d = CHSB_S_IDLE;
            end
            default:
                tx_st_d = CHSB_S_IDLE;
        endcase
        if (mode_q != CHSB_MODE_TX || ext_b)
        begin
            tx_st_d   = CHSB_S_IDLE;
            tx_line_d = LINE_MARK;
            tx_flag_d = tx_write ? 1'h0 : tx_flag_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_st_q   <= CHSB_S_IDLE;
            tx_cnt_q  <= '0;
            tx_bit_q  <= '0;
            tx_sh_q   <= '0;
            tx_buf_q  <= '0;
            tx_flag_q <= TX_FLAG_RST;
            tx_line_q <= LINE_MARK;
        end
        else
        begin
            tx_st_q   <= tx_st_d;
            tx_cnt_q  <= tx_cnt_d;
            tx_bit_q  <= tx_bit_d;
            tx_sh_q   <= tx_sh_d;
            tx_buf_q  <= tx_buf_d;
            tx_flag_q <= tx_flag_d;
            tx_line_q <= tx_line_d;
        end
    end

    a_rx_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        rx_done |=> rx_flag_q && rx_st_q == CHSB_S_IDLE)
        else $error("Receive flag not set after character");
    a_rx_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
        rx_read && !rx_done |=> !rx_flag_q && rx_data_q == '0)
        else $error("Read did not clear receive flag and data");
    a_noise_reject: assert property (@(posedge clk) disable iff (sys_rst)
        rx_st_q == CHSB_S_START && line_s == LINE_MARK
        |=> rx_st_q == CHSB_S_IDLE)
        else $error("Short space pulse not rejected");
    a_char_width: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(rx_flag_q) |-> (rx_data_q & ~char_mask(char_width_sel)) == '0)
        else $error("Received data wider than character");
    a_half_duplex: assert property (@(posedge clk) disable iff (sys_rst)
        !(rx_st_q != CHSB_S_IDLE && tx_st_q != CHSB_S_IDLE))
        else $error("Receiver and transmitter active together");
    a_tx_write_clear: assert property (@(posedge clk) disable iff (sys_rst)
        tx_write |=> !tx_flag_q)
        else $error("Transmit write did not clear flag");
    a_tx_idle_mark: assert property (@(posedge clk) disable iff (sys_rst)
        tx_st_q == CHSB_S_IDLE |-> tx_line_q == LINE_MARK)
        else $error("Line not at mark while transmitter idle");
    a_tx_load_start: assert property (@(posedge clk) disable iff (sys_rst)
        tx_st_q == CHSB_S_IDLE && $past(tx_st_q) == CHSB_S_IDLE
        && mode_q == CHSB_MODE_TX && $past(mode_q) == CHSB_MODE_TX
        && !tx_flag_q && !tx_write && !ext_b
        |=> tx_flag_q && tx_st_q == CHSB_S_START && tx_line_q == LINE_SPACE)
        else $error("Waiting character not loaded with start bit");
endmodule // chsb_channel
`default_nettype wire

// ==== hdl/chsb_pkg.sv ====
// Constants and types for the character serial buffer channel.
// Assumes a single 200 MHz clock domain and line speeds of 300 b/s or more.
package chsb_pkg;
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned MIN_LINE_BPS = 300;
    localparam int unsigned MAX_BIT_CYC  = CLK_HZ / MIN_LINE_BPS;
    localparam int unsigned DIV_W        = $clog2(MAX_BIT_CYC + 1);

    localparam int unsigned DATA_W  = 8;
    localparam int unsigned SHIFT_W = DATA_W + 1;
    localparam int unsigned CMD_W   = 4;
    localparam int unsigned SEL_W   = 2;
    localparam int unsigned BITS_W  = 4;

    localparam logic [BITS_W-1:0] MIN_CHAR_BITS = 4'h5;
    localparam logic              LINE_MARK     = 1'h1;
    localparam logic              LINE_SPACE    = 1'h0;

    // Control command codes
    localparam logic [CMD_W-1:0] clear_receive_cmd      = 4'h1;
    localparam logic [CMD_W-1:0] set_receive_mode_cmd   = 4'h3;
    localparam logic [CMD_W-1:0] set_transmit_mode_cmd  = 4'h4;
    localparam logic [CMD_W-1:0] extended_control_cmd_a = 4'h5;
    localparam logic [CMD_W-1:0] extended_control_cmd_b = 4'h6;

    // Flag test codes
    localparam logic [CMD_W-1:0] rx_flag_test       = 4'h1;
    localparam logic [CMD_W-1:0] tx_flag_test       = 4'h2;
    localparam logic [CMD_W-1:0] extended_flag_test = 4'h9;

    // Reset values
    localparam logic RX_FLAG_RST = 1'h0;
    localparam logic TX_FLAG_RST = 1'h1;

    typedef enum logic [1:0] {
        CHSB_MODE_OFF = 2'h0,
        CHSB_MODE_RX  = 2'h1,
        CHSB_MODE_TX  = 2'h2
    } chsb_mode_e;

    // Gray order along idle, start, data, stop
    typedef enum logic [1:0] {
        CHSB_S_IDLE  = 2'h0,
        CHSB_S_START = 2'h1,
        CHSB_S_DATA  = 2'h3,
        CHSB_S_STOP  = 2'h2
    } chsb_state_e;
endpackage

// ==== hdl/chsb_sync2.sv ====
// Two-stage synchroniser for the serial receive pin.
// Assumes the pin idles at mark; reset loads mark.
`timescale 1ns/10ps
`default_nettype none
module chsb_sync2
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    output var  logic pin_s_q
);
    logic meta_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q  <= 1'h1;
            pin_s_q <= 1'h1;
        end
        else
        begin
            meta_q  <= pin_in;
            pin_s_q <= meta_q;
        end
    end
endmodule // chsb_sync2
`default_nettype wire

// ==== bench/chsb_remote.sv ====
// Remote terminal model on the far side of the serial line.
// Assumes the bench clock; bit timing counted in whole cycles.
`timescale 1ns/10ps
`default_nettype none
module chsb_remote
#(
    parameter int PER = 8
)
(
    input  wire logic       clk,
    input  wire logic [3:0] char_bits,
    input  wire logic       line_in,
    output var  logic       line_out,
    output var  logic [7:0] got_char,
    output var  int         got_count
);
    initial
    begin
        line_out  = 1'b1;
        got_char  = 8'h00;
        got_count = 0;
    end

    task automatic drive_bit(input logic b);
        #1 line_out = b;
        repeat (PER) @(posedge clk);
    endtask

    // Idle mark, space start, data low bit first, mark stop
    task automatic send_char(input logic [7:0] d);
        int i;
        @(posedge clk);
        drive_bit(1'b0);
        for (i = 0; i < char_bits; i++)
            drive_bit(d[i]);
        drive_bit(1'b1);
    endtask

    // Short space burst, too brief to count as a start
    task automatic glitch(input int n);
        @(posedge clk);
        #1 line_out = 1'b0;
        repeat (n) @(posedge clk);
        #1 line_out = 1'b1;
    endtask

    // Mid-bit sampling of the channel's transmit line
    initial
    begin : rx_watch
        int i;
        logic [7:0] sh;
        forever
        begin
            @(posedge clk) #1;
            if (line_in === 1'b0)
            begin
                sh = 8'h00;
                repeat (PER / 2) @(posedge clk);
                for (i = 0; i < char_bits; i++)
                begin
                    repeat (PER) @(posedge clk);
                    #1 sh[i] = line_in;
                end
                repeat (PER) @(posedge clk);
                got_char = sh;
                got_count++;
            end
        end
    end
endmodule // chsb_remote
`default_nettype wire

// ==== bench/chsb_channel_bench.sv ====
// Self-checking bench for the character serial buffer channel.
// Assumes chsb_remote as far side and an 8-cycle bit period.
`timescale 1ns/10ps
`default_nettype none
module chsb_channel_bench;
    import chsb_pkg::*;
    localparam int PER   = 8;
    localparam int LIMIT = 20000;
    logic              clk;
    logic              sys_rst;
    logic              rx_line;
    logic              tx_line_q;
    logic [SEL_W-1:0]  char_width_sel;
    logic              full_variant;
    logic              cmd_valid;
    logic [CMD_W-1:0]  cmd_code;
    logic              tx_write;
    logic [DATA_W-1:0] tx_data;
    logic              rx_read;
    logic [DATA_W-1:0] rx_char_q;
    logic              rx_flag_q;
    logic              tx_flag_q;
    logic              test_valid;
    logic [CMD_W-1:0]  test_code;
    logic              test_result_q;
    logic              rx_mode_q;
    logic              tx_mode_q;
    logic [3:0]        char_bits;
    logic [7:0]        got_char;
    int                got_count;
    int                err_total = 0;
    int                total_checks = 0;
    int                cyc = 0;
    int                i;
    logic              r;
    logic [7:0]        v;
    logic [7:0]        pat;

    assign char_bits = 4'h5 + {2'h0, char_width_sel};

    chsb_channel u_chsb_channel
    (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .rx_line_in     (rx_line),
        .tx_line_q      (tx_line_q),
        .char_width_sel (char_width_sel),
        .bit_period     (DIV_W'(PER)),
        .full_variant   (full_variant),
        .cmd_valid      (cmd_valid),
        .cmd_code       (cmd_code),
        .tx_write       (tx_write),
        .tx_data        (tx_data),
        .rx_read        (rx_read),
        .rx_char_q      (rx_char_q),
        .rx_flag_q      (rx_flag_q),
        .tx_flag_q      (tx_flag_q),
        .test_valid     (test_valid),
        .test_code      (test_code),
        .test_result_q  (test_result_q),
        .rx_mode_q      (rx_mode_q),
        .tx_mode_q      (tx_mode_q)
    );

    chsb_remote #(.PER(PER)) u_chsb_remote
    (
        .clk       (clk),
        .char_bits (char_bits),
        .line_in   (tx_line_q),
        .line_out  (rx_line),
        .got_char  (got_char),
        .got_count (got_count)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop;
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Ceiling well above the thousand or so cycles the tests need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            err_total++;
            report_and_stop;
        end
    end

    task automatic check_bit(input logic got, input logic exp,
                             input string msg);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                              input string msg);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic do_reset(input logic [SEL_W-1:0] sel, input logic full);
        @(posedge clk) #1;
        sys_rst = 1'b1;
        char_width_sel = sel;
        full_variant = full;
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'b0;
    endtask

    // Pulses stand one cycle; an extra edge lets the answer land
    task automatic send_cmd(input logic [CMD_W-1:0] c);
        @(posedge clk) #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        @(posedge clk) #1;
    endtask

    task automatic write_tx(input logic [7:0] d);
        @(posedge clk) #1;
        tx_write = 1'b1;
        tx_data = d;
        @(posedge clk) #1;
        tx_write = 1'b0;
    endtask

    task automatic read_rx(output logic [7:0] d);
        @(posedge clk) #1;
        rx_read = 1'b1;
        @(posedge clk) #1;
        rx_read = 1'b0;
        @(posedge clk) #1;
        d = rx_char_q;
    endtask

    task automatic run_test(input logic [CMD_W-1:0] c, output logic res);
        @(posedge clk) #1;
        test_valid = 1'b1;
        test_code = c;
        @(posedge clk) #1;
        test_valid = 1'b0;
        @(posedge clk) #1;
        res = test_result_q;
    endtask

    task automatic wait_sig(ref logic s, input int n);
        int k;
        for (k = 0; k < n && s !== 1'b1; k++)
            @(posedge clk) #1;
        check_bit(s, 1'b1, "wait ran out");
    endtask

    task automatic wait_count(input int n);
        int k;
        for (k = 0; k < 40 * PER && got_count < n; k++)
            @(posedge clk) #1;
        check_bit(got_count >= n, 1'b1, "frame missing");
    endtask

    initial
    begin
        sys_rst = 1'b1;
        char_width_sel = '0;
        full_variant = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = '0;
        tx_write = 1'b0;
        tx_data = '0;
        rx_read = 1'b0;
        test_valid = 1'b0;
        test_code = '0;
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'b0;
        check_bit(tx_line_q, LINE_MARK, "idle line");
        check_bit(rx_flag_q, RX_FLAG_RST, "rx flag reset");
        // Each width, reduced and full variant alternating
        for (i = 0; i < 4; i++)
        begin
            pat = 8'hA5 ^ 8'(i * 17);
            do_reset(SEL_W'(i), i[0]);
            send_cmd(set_receive_mode_cmd);
            check_bit(rx_mode_q, 1'b1, "rx mode");
            check_bit(tx_mode_q, 1'b0, "tx mode off");
            fork
                u_chsb_remote.send_char(pat);
                begin
                    repeat (3 * PER) @(posedge clk);
                    run_test(extended_flag_test, r);
                end
            join
            check_bit(r, i[0], "busy test");
            repeat (2) @(posedge clk);
            #1 check_bit(rx_flag_q, 1'b1, "rx flag set");
            run_test(rx_flag_test, r);
            check_bit(r, 1'b1, "flag test");
            read_rx(v);
            check_byte(v, pat & 8'((1 << (5 + i)) - 1), "rx char");
            check_bit(rx_flag_q, 1'b0, "flag cleared");
        end
        // Back-to-back frames, second overwrites unread first
        u_chsb_remote.send_char(8'h3C);
        u_chsb_remote.send_char(8'hC3);
        repeat (2) @(posedge clk);
        #1 check_bit(rx_flag_q, 1'b1, "second frame");
        read_rx(v);
        check_byte(v, 8'hC3, "overwrite");
        u_chsb_remote.glitch(PER / 2 - 2);
        repeat (12 * PER) @(posedge clk);
        #1 check_bit(rx_flag_q, 1'b0, "noise ignored");
        u_chsb_remote.send_char(8'h81);
        send_cmd(clear_receive_cmd);
        check_bit(rx_flag_q, 1'b0, "clear cmd flag");
        read_rx(v);
        check_byte(v, 8'h00, "clear cmd data");
        // All-mark data after the abort cannot restart the receiver
        fork
            u_chsb_remote.send_char(8'hFF);
            begin
                repeat (3 * PER) @(posedge clk);
                send_cmd(extended_control_cmd_a);
            end
        join
        repeat (2) @(posedge clk);
        #1 check_bit(rx_flag_q, 1'b0, "receive abort");
        // Transmit side, five-bit characters
        do_reset(SEL_W'(0), 1'b1);
        send_cmd(set_transmit_mode_cmd);
        check_bit(tx_mode_q, 1'b1, "tx mode");
        u_chsb_remote.send_char(8'h55);
        repeat (2) @(posedge clk);
        #1 check_bit(rx_flag_q, 1'b0, "half duplex");
        write_tx(8'hF6);
        check_bit(tx_flag_q, 1'b0, "tx flag clear");
        wait_sig(tx_flag_q, 10);
        check_bit(tx_line_q, LINE_SPACE, "start bit");
        write_tx(8'h0B);
        wait_count(1);
        check_byte(got_char, 8'h16, "tx char one");
        wait_count(2);
        check_byte(got_char, 8'h0B, "tx char two");
        run_test(tx_flag_test, r);
        check_bit(r, 1'b1, "tx flag test");
        v = 8'h00;
        repeat (3 * PER)
        begin
            @(posedge clk) #1;
            if (tx_line_q !== LINE_MARK)
                v++;
        end
        check_byte(v, 8'h00, "marks while flag set");
        // Abort of a frame of spaces, full variant only
        write_tx(8'h00);
        wait_sig(tx_flag_q, 10);
        send_cmd(extended_control_cmd_b);
        check_bit(tx_line_q, LINE_MARK, "abort to mark");
        report_and_stop;
    end
endmodule // chsb_channel_bench
`default_nettype wire
